// ===== logic/ddrsc_pkg.sv
// Shared constants and types for the read strobe capture block.
// Assumes a single 50 MHz system clock and a plain register port.
package ddrsc_pkg;
  // Strobe group geometry
  localparam int CELLS_PER_GROUP = 12;
  localparam int DQ_PER_STROBE   = 10;
  localparam int EQ_W            = 2;
  localparam int ADDR_W          = 4;
  localparam int DATA_W          = 32;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_EQ     = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h8;

  // Control and status bit positions
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_DIFF_BIT = 1;
  localparam int ST_POL_BIT    = 0;
  localparam int ST_LOCK_BIT   = 1;
  localparam int ST_OVF_BIT    = 2;
  localparam int ST_EDGE_LSB   = 4;

  // Reset values
  localparam logic [1:0]      CTRL_RESET = 2'h0;
  localparam logic [EQ_W-1:0] EQ_NONE    = 2'h0;

  typedef enum logic [1:0] {
    DDRSC_EDGE_LEFT   = 2'b00,
    DDRSC_EDGE_RIGHT  = 2'b01,
    DDRSC_EDGE_TOP    = 2'b10,
    DDRSC_EDGE_BOTTOM = 2'b11
  } ddrsc_edge_e;

  typedef enum logic [1:0] {
    DDRSC_IDLE      = 2'b00,
    DDRSC_WAIT_PRE  = 2'b01,
    DDRSC_WAIT_RISE = 2'b10,
    DDRSC_LOCKED    = 2'b11
  } ddrsc_state_e;

  // One captured beat pair
  typedef struct packed {
    logic [DQ_PER_STROBE-1:0] rise;
    logic [DQ_PER_STROBE-1:0] fall;
  } ddrsc_beat_s;
endpackage

// ===== logic/ddrsc_capture.sv
// Read strobe capture for one strobe group, with polarity control.
// Assumes pins arrive asynchronously and a core read pulse marks each read.
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module ddrsc_capture
  import ddrsc_pkg::*;
#(
  parameter ddrsc_edge_e EDGE = DDRSC_EDGE_LEFT,
  parameter int          DQ_W = ddrsc_pkg::DQ_PER_STROBE
) (
  input  wire logic                           i_clk_sys,
  input  wire logic                           i_reset,
  input  wire logic [ddrsc_pkg::ADDR_W-1:0]   i_addr,
  input  wire logic [ddrsc_pkg::DATA_W-1:0]   i_wdata,
  input  wire logic                           i_wr,
  input  wire logic                           i_rd,
  output logic      [ddrsc_pkg::DATA_W-1:0]   o_rdata,
  input  wire logic                           i_read_start,
  input  wire logic                           i_strobe_t,
  input  wire logic                           i_strobe_c,
  input  wire logic [DQ_W-1:0]                i_dq,
  output logic                                o_rd_valid,
  output ddrsc_pkg::ddrsc_beat_s              o_rd_beat,
  input  wire logic                           i_rd_ready,
  output logic                                o_read_clock_polarity,
  output logic                                o_read_transfer_latch,
  output logic      [DQ_W*ddrsc_pkg::EQ_W-1:0] o_eq_setting,
  output logic      [ddrsc_pkg::EQ_W-1:0]     o_eq_strobe_comp,
  output logic                                o_out_gearing_en
);
  import ddrsc_pkg::*;

  // Edge capabilities
  localparam logic EDGE_DDR  = (EDGE != DDRSC_EDGE_BOTTOM);
  localparam logic EDGE_GEAR = (EDGE == DDRSC_EDGE_LEFT) ||
                               (EDGE == DDRSC_EDGE_RIGHT);

  // Pin synchronisers, two flops each
  logic [DQ_W-1:0] dq_m_reg, dq_s_reg;
  logic            st_t_m_reg, st_t_s_reg, st_c_m_reg, st_c_s_reg;
  logic            strobe_prev_reg;

  // Registers and state
  logic [1:0]           ctrl_reg;
  logic [DQ_W*EQ_W-1:0] eq_reg;
  logic                 ovf_reg;
  ddrsc_state_e         state_reg, state_next;
  logic                 phase_reg;
  logic                 pol_reg;
  logic [DQ_W-1:0]      rise_reg, fall_reg;
  logic                 pend_reg;
  ddrsc_beat_s          xfer_reg;
  logic                 latch_reg;
  ddrsc_beat_s          spare_reg;
  logic                 spare_v_reg;

  always_ff @(posedge i_clk_sys) begin
    dq_m_reg   <= i_dq;
    dq_s_reg   <= dq_m_reg;
    st_t_m_reg <= i_strobe_t;
    st_t_s_reg <= st_t_m_reg;
    st_c_m_reg <= i_strobe_c;
    st_c_s_reg <= st_c_m_reg;
  end

  // Strobe recovery and edge detection
  wire logic diff_en  = ctrl_reg[CTRL_DIFF_BIT];
  wire logic cap_en   = ctrl_reg[CTRL_EN_BIT] && EDGE_DDR;
  wire logic strobe   = diff_en ? (st_t_s_reg & ~st_c_s_reg)
                                : st_t_s_reg;
  wire logic st_rise  = strobe && !strobe_prev_reg;
  wire logic st_fall  = !strobe && strobe_prev_reg;
  wire logic locked   = (state_reg == DDRSC_LOCKED);
  // The locking rise already carries the first beat of the burst
  wire logic armed    = locked || (state_reg == DDRSC_WAIT_RISE);
  wire logic cap_rise = cap_en && armed && st_rise;
  wire logic cap_fall = cap_en && locked && st_fall;

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      strobe_prev_reg <= 1'b1;
    end else begin
      strobe_prev_reg <= strobe;
    end
  end

  // Register decode
  wire logic wr_ctrl   = i_wr && (i_addr == ADDR_CTRL);
  wire logic wr_eq     = i_wr && (i_addr == ADDR_EQ);
  wire logic wr_status = i_wr && (i_addr == ADDR_STATUS);
  wire logic [DATA_W-1:0] status_word =
    DATA_W'({EDGE, 1'b0, ovf_reg, locked, pol_reg}) ;
  wire logic [DATA_W-1:0] rd_mux =
    (i_addr == ADDR_CTRL)   ? DATA_W'(ctrl_reg) :
    (i_addr == ADDR_EQ)     ? DATA_W'(eq_reg)   :
    (i_addr == ADDR_STATUS) ? status_word       : '0;

  // Equalisation mask: differential keeps complement pins at none
  wire logic [EQ_W-1:0] eq_comp = diff_en ? EQ_NONE
                                          : eq_reg[EQ_W-1:0];

  // Control and equalisation registers
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      ctrl_reg <= CTRL_RESET;
      eq_reg   <= '0;
      o_rdata  <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= i_wdata[1:0];
      end
      if (wr_eq) begin
        eq_reg <= i_wdata[DQ_W*EQ_W-1:0];
      end
      o_rdata <= i_rd ? rd_mux : '0;
    end
  end

  // Half-rate phase of the system clock
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      phase_reg <= 1'b0;
    end else begin
      phase_reg <= !phase_reg;
    end
  end

  // Arming sequence for polarity detection
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      DDRSC_IDLE: begin
        if (i_read_start && cap_en) begin
          state_next = DDRSC_WAIT_PRE;
        end
      end
      DDRSC_WAIT_PRE: begin
        if (!strobe) begin
          state_next = DDRSC_WAIT_RISE;
        end
      end
      DDRSC_WAIT_RISE: begin
        if (st_rise) begin
          state_next = DDRSC_LOCKED;
        end
      end
      DDRSC_LOCKED: begin
        if (i_read_start) begin
          state_next = DDRSC_WAIT_PRE;
        end
      end
    endcase
    if (!cap_en) begin
      state_next = DDRSC_IDLE;
    end
  end

  // Polarity latch, held for the whole read
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      state_reg <= DDRSC_IDLE;
      pol_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg == DDRSC_WAIT_RISE && st_rise) begin
        pol_reg <= phase_reg;
      end
    end
  end

  // Rise and fall capture for every lane on the strobe bus
  generate
    for (genvar g = 0; g < DQ_W; g++) begin : g_lane
      always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
          rise_reg[g] <= 1'b0;
          fall_reg[g] <= 1'b0;
        end else begin
          if (cap_rise) begin
            rise_reg[g] <= dq_s_reg[g];
          end
          if (cap_fall) begin
            fall_reg[g] <= dq_s_reg[g];
          end
        end
      end
    end
  endgenerate

  // Handoff timing on the selected phase
  wire logic do_latch = pend_reg && (phase_reg == pol_reg);
  wire logic pop      = o_rd_valid && i_rd_ready;
  wire logic accept   = !spare_v_reg;
  wire logic push     = latch_reg && accept;

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      pend_reg  <= 1'b0;
      latch_reg <= 1'b0;
      xfer_reg  <= '0;
    end else begin
      latch_reg <= do_latch;
      if (cap_fall) begin
        pend_reg <= 1'b1;
      end else if (do_latch) begin
        pend_reg <= 1'b0;
      end
      if (do_latch) begin
        xfer_reg <= '{rise: rise_reg, fall: fall_reg};
      end
    end
  end

  // Two-entry output buffer: head is the output, spare absorbs a stall
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_rd_valid  <= 1'b0;
      o_rd_beat   <= '0;
      spare_v_reg <= 1'b0;
      spare_reg   <= '0;
    end else if (pop && spare_v_reg) begin
      o_rd_beat   <= spare_reg;
      spare_reg   <= xfer_reg;
      spare_v_reg <= push;
    end else if (pop) begin
      o_rd_beat  <= xfer_reg;
      o_rd_valid <= push;
    end else if (push && !o_rd_valid) begin
      o_rd_beat  <= xfer_reg;
      o_rd_valid <= 1'b1;
    end else if (push) begin
      spare_reg   <= xfer_reg;
      spare_v_reg <= 1'b1;
    end
  end

  // Overflow flag: a new loss wins over a clear
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      ovf_reg <= 1'b0;
    end else if (latch_reg && !accept) begin
      ovf_reg <= 1'b1;
    end else if (wr_status && i_wdata[ST_OVF_BIT]) begin
      ovf_reg <= 1'b0;
    end
  end

  // Registered side outputs
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_read_clock_polarity <= 1'b0;
      o_read_transfer_latch <= 1'b0;
      o_eq_setting          <= '0;
      o_eq_strobe_comp      <= EQ_NONE;
      o_out_gearing_en      <= 1'b0;
    end else begin
      o_read_clock_polarity <= pol_reg;
      o_read_transfer_latch <= do_latch;
      o_eq_setting          <= eq_reg;
      o_eq_strobe_comp      <= eq_comp;
      o_out_gearing_en      <= EDGE_GEAR;
    end
  end

  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  sequence s_armed_rise;
    state_reg == DDRSC_WAIT_RISE && st_rise;
  endsequence
  sequence s_locked_phase;
    locked && pol_reg == $past(phase_reg);
  endsequence

  property p_rise_capture;
    cap_rise |=> rise_reg == $past(dq_s_reg);
  endproperty
  a_rise_capture: assert property (p_rise_capture)
    else $error("rise register missed the data");

  property p_first_rise;
    s_armed_rise |=> s_locked_phase;
  endproperty
  a_first_rise: assert property (p_first_rise)
    else $error("polarity not set on first rise");

  property p_pol_hold;
    locked && !i_read_start |=> $stable(pol_reg);
  endproperty
  a_pol_hold: assert property (p_pol_hold)
    else $error("polarity moved during a read");

  property p_rearm;
    locked && i_read_start && cap_en |=> state_reg == DDRSC_WAIT_PRE;
  endproperty
  a_rearm: assert property (p_rearm)
    else $error("new read did not rearm polarity");

  property p_latch_phase;
    pend_reg && phase_reg == pol_reg |=> o_read_transfer_latch ##1
      (o_rd_valid || ovf_reg);
  endproperty
  a_latch_phase: assert property (p_latch_phase)
    else $error("transfer latch mistimed");

  property p_pol_out;
    ##1 o_read_clock_polarity == $past(pol_reg);
  endproperty
  a_pol_out: assert property (p_pol_out)
    else $error("polarity output disagrees");

  property p_bottom;
    EDGE == DDRSC_EDGE_BOTTOM |-> !o_rd_valid && !locked;
  endproperty
  a_bottom: assert property (p_bottom)
    else $error("bottom edge captured data");

  property p_eq_write;
    wr_eq |-> ##2 o_eq_setting == $past(i_wdata[DQ_W*EQ_W-1:0], 2);
  endproperty
  a_eq_write: assert property (p_eq_write)
    else $error("equalisation setting not applied");

  property p_eq_diff;
    diff_en |=> o_eq_strobe_comp == EQ_NONE;
  endproperty
  a_eq_diff: assert property (p_eq_diff)
    else $error("complement equalised in differential mode");

  property p_no_loss;
    spare_v_reg && !pop |=> spare_v_reg && o_rd_valid;
  endproperty
  a_no_loss: assert property (p_no_loss)
    else $error("buffered word dropped");
endmodule

// ===== tb/ddrsc_mem_model.sv
// Memory side of one strobe group: preamble, strobe and data beats.
// Assumes bursts are started only while the link is idle.
`timescale 1ns/1ps
module ddrsc_mem_model
  import ddrsc_pkg::*;
(
  input  wire logic        i_go,
  input  wire logic [3:0]  i_beats,
  input  wire ddrsc_beat_s i_first,
  output logic             o_strobe_t,
  output logic             o_strobe_c,
  output logic [9:0]       o_dq
);
  ddrsc_beat_s b;
  logic        s;

  // Idle strobe floats high on termination
  initial begin
    s = 1'b1;
    o_dq = 10'h155;
  end
  assign o_strobe_t = s;
  assign o_strobe_c = ~s;

  // One burst: preamble low, then rise and fall beats
  always @(posedge i_go) begin
    b = i_first;
    #7 s = 1'b0;
    #160;
    repeat (i_beats) begin
      o_dq = b.rise;
      #40 s = 1'b1;
      #40 o_dq = b.fall;
      #40 s = 1'b0;
      #40 b = ddrsc_beat_s'(b + 20'h1);
    end
    // Released data no longer shows the last value
    o_dq = ~o_dq;
    #80 s = 1'b1;
  end
endmodule

// ===== tb/ddr_read_strobe_capture_tb_top.sv
// Bench for the read strobe capture block: registers, bursts, stalls.
// Assumes the memory model of this folder and the design package.
`timescale 1ns/1ps
module ddr_read_strobe_capture_tb_top;
  import ddrsc_pkg::*;
  logic        clk, rst, wr, rd, rs, rdy, go, rd_d, hold_ok, pol_h;
  logic        st_t, st_c, vld, pol, lat, gear, gear_b, vld_b;
  logic        gear_t, vld_t;
  logic [3:0]  addr, nb;
  logic [31:0] wdata, rdata, seed, rr, v;
  logic [9:0]  dq;
  logic [19:0] eq;
  logic [1:0]  eqc, mode;
  ddrsc_beat_s beat, first;
  int          err_total, samples_checked, lat_cnt;
  logic [31:0] reg_q[$], msk_q[$];
  ddrsc_beat_s beat_q[$];

  ddrsc_capture i_dut (.i_clk_sys(clk), .i_reset(rst), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_read_start(rs), .i_strobe_t(st_t), .i_strobe_c(st_c), .i_dq(dq),
    .o_rd_valid(vld), .o_rd_beat(beat), .i_rd_ready(rdy),
    .o_read_clock_polarity(pol), .o_read_transfer_latch(lat),
    .o_eq_setting(eq), .o_eq_strobe_comp(eqc), .o_out_gearing_en(gear));
  ddrsc_capture #(.EDGE(DDRSC_EDGE_BOTTOM)) i_dut_bot (.i_clk_sys(clk),
    .i_reset(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(), .i_read_start(rs), .i_strobe_t(st_t), .i_strobe_c(st_c),
    .i_dq(dq), .o_rd_valid(vld_b), .o_rd_beat(), .i_rd_ready(rdy),
    .o_read_clock_polarity(), .o_read_transfer_latch(),
    .o_eq_setting(), .o_eq_strobe_comp(), .o_out_gearing_en(gear_b));
  // Top edge: capture as on the sides, but no output gearing
  ddrsc_capture #(.EDGE(DDRSC_EDGE_TOP)) i_dut_top (.i_clk_sys(clk),
    .i_reset(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(), .i_read_start(rs), .i_strobe_t(st_t), .i_strobe_c(st_c),
    .i_dq(dq), .o_rd_valid(vld_t), .o_rd_beat(), .i_rd_ready(rdy),
    .o_read_clock_polarity(), .o_read_transfer_latch(),
    .o_eq_setting(), .o_eq_strobe_comp(), .o_out_gearing_en(gear_t));
  ddrsc_mem_model i_mem (.i_go(go), .i_beats(nb), .i_first(first),
    .o_strobe_t(st_t), .o_strobe_c(st_c), .o_dq(dq));

  // 50 MHz system clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [3:0] a, input logic [31:0] e,
                      input logic [31:0] m);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    reg_q.push_back(e);
    msk_q.push_back(m);
    @(posedge clk);
    rd <= 1'b0;
  endtask

  // Start a read, note the beats that must come out
  task automatic burst(input logic [3:0] n, input int keep, input int nl);
    int l0;
    seed = xs(seed);
    first = seed[19:0];
    hold_ok = 1'b0;
    l0 = lat_cnt;
    for (int k = 0; k < keep; k++)
      beat_q.push_back(ddrsc_beat_s'(first + 20'(k)));
    @(posedge clk) rs <= 1'b1;
    @(posedge clk) rs <= 1'b0;
    nb <= n;
    go <= 1'b1;
    cyc(3);
    go <= 1'b0;
    cyc(8 * n + 30);
    chk(lat_cnt - l0, nl);
  endtask

  // Consumer: ready, random or stalled
  always @(posedge clk) begin
    rr = xs(rr);
    rdy <= (mode == 2'h0) || (mode == 2'h1 && rr[0]);
  end

  // Take the oldest note whenever a result shows
  always @(posedge clk) begin
    if (rd_d)
      chk(rdata & msk_q.pop_front(), reg_q.pop_front());
    if (vld && rdy) chk(beat, beat_q.pop_front());
    if (vld_b) chk(vld_b, 1'b0);
    if (vld || vld_t) chk(vld_t, vld);
    if (lat && hold_ok) chk(pol, pol_h);
    if (lat) begin
      pol_h <= pol;
      hold_ok <= 1'b1;
    end
    lat_cnt += int'(lat);
    rd_d <= rd;
  end

  task automatic close_out;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog
  initial begin
    #1000000;
    err_total++;
    close_out();
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    rs = 1'b0;
    go = 1'b0;
    rdy = 1'b1;
    mode = 2'h0;
    addr = 4'h0;
    wdata = 32'h0;
    nb = 4'h0;
    first = '0;
    seed = 32'h3791;
    rr = 32'h3791;
    rd_d = 1'b0;
    hold_ok = 1'b0;
    pol_h = 1'b0;
    cyc(4);
    rst <= 1'b0;
    rreg(ADDR_CTRL, 32'h0, '1);
    rreg(ADDR_EQ, 32'h0, '1);
    rreg(ADDR_STATUS, 32'h0, '1);
    rreg(4'hc, 32'h0, '1);
    chk(gear, 1'b1);
    chk(gear_b, 1'b0);
    chk(gear_t, 1'b0);
    for (int s = 0; s < 4; s++) begin
      v = '0;
      for (int g = 0; g < 10; g++)
        v[2*g +: 2] = 2'(s + g);
      wreg(ADDR_EQ, v);
      cyc(2);
      chk(eq, v[19:0]);
      chk(eqc, v[1:0]);
      rreg(ADDR_EQ, v, '1);
    end
    wreg(ADDR_CTRL, 32'h1);
    mode <= 2'h1;
    burst(4'h4, 4, 4);
    rreg(ADDR_STATUS, 32'h2, 32'hfffffffe);
    // Stalled consumer: two beats kept, the rest lost
    mode <= 2'h2;
    burst(4'h4, 2, 4);
    mode <= 2'h0;
    cyc(4);
    rreg(ADDR_STATUS, 32'h4, 32'hfffffffc);
    wreg(ADDR_STATUS, 32'h4);
    rreg(ADDR_STATUS, 32'h0, 32'hfffffffc);
    // Differential strobe with a random equaliser word
    wreg(ADDR_CTRL, 32'h3);
    seed = xs(seed);
    wreg(ADDR_EQ, {12'h0, seed[19:0]});
    cyc(2);
    chk(eq, seed[19:0]);
    chk(eqc, 2'h0);
    mode <= 2'h1;
    burst(4'h3, 3, 3);
    // Capture disabled: nothing comes out
    wreg(ADDR_CTRL, 32'h0);
    burst(4'h2, 0, 0);
    mode <= 2'h0;
    cyc(4);
    chk(beat_q.size(), 0);
    close_out();
  end
endmodule
